// ===== design/ssp_defs.svh
// Constants of the split-port burst SRAM block
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_DW 36
`define SSP_AW 19
`define SSP_LANE_W 9
`define SSP_LANES 4
`define SSP_NIB_W 4
`define SSP_NIBS 2
`define SSP_BURST 4
`define SSP_IDX_W 4
`define SSP_MEM_DEPTH 16
`define SSP_NIBBLE_MODE 1'b0
`define SSP_FIFO_DEPTH 4
`define SSP_OE_OFF 1'b1
`define SSP_Q_RST 36'h0
`endif

// ===== design/ssp_pkg.sv
// Types of the split-port burst SRAM block
package ssp_pkg;
`include "ssp_defs.svh"
	typedef logic [`SSP_DW-1:0] ssp_word_t;
	typedef enum logic [4:0] {
		SSP_WR_IDLE = 5'h01,
		SSP_WR_ARM = 5'h02,
		SSP_WR_B1 = 5'h04,
		SSP_WR_B2 = 5'h08,
		SSP_WR_B3 = 5'h10
	} ssp_wr_e;
	typedef enum logic [2:0] {
		SSP_RD_IDLE = 3'h1,
		SSP_RD_BURST = 3'h2,
		SSP_RD_TAIL = 3'h4
	} ssp_rd_e;
	typedef struct packed {
		logic [`SSP_IDX_W-1:0] idx;
		logic [1:0] word;
		ssp_word_t data;
		ssp_word_t keep;
	} ssp_beat_s;
	typedef struct packed {
		logic k;
		logic kn;
		logic c;
		logic cn;
		logic single;
		logic wps_n;
		logic rps_n;
		logic [`SSP_AW-1:0] addr;
		ssp_word_t d;
		logic [`SSP_LANES-1:0] bws_n;
		logic [`SSP_NIBS-1:0] nws_n;
	} ssp_pins_s;
endpackage

// ===== design/ssp_sram.sv
// Split-port double-data-rate burst SRAM: pin capture, write FIFO, array, read output
`timescale 1ns/1ps
`include "ssp_defs.svh"

// ----------------------------------------
// FIFO between write capture and array
// ----------------------------------------
module ssp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Handshake status
	assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rp_r];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Pointer and level update
	always_comb begin
		wp_nxt = push ? wp_r + PW'(1) : wp_r;
		rp_nxt = pop ? rp_r + PW'(1) : rp_r;
		cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end
endmodule // ssp_fifo

// ----------------------------------------
// Device top
// ----------------------------------------
module ssp_sram_split_port (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	// Link clocks and mode strap
	input wire logic CAPTURE_CLOCK_P_I,
	input wire logic CAPTURE_CLOCK_N_I,
	input wire logic OUTPUT_CLOCK_P_I,
	input wire logic OUTPUT_CLOCK_N_I,
	input wire logic SINGLE_CLOCK_MODE_I,
	// Port selects and address
	input wire logic WRITE_PORT_SELECT_N_I,
	input wire logic READ_PORT_SELECT_N_I,
	input wire logic [`SSP_AW-1:0] SHARED_ADDR_BUS_I,
	// Write data and masks
	input wire ssp_pkg::ssp_word_t WRITE_DATA_IN_I,
	input wire logic [`SSP_LANES-1:0] BYTE_WRITE_SELECT_N_I,
	input wire logic [`SSP_NIBS-1:0] NIBBLE_WRITE_SELECT_N_I,
	// Read data
	output ssp_pkg::ssp_word_t READ_DATA_OUT_O,
	output logic READ_DATA_OUT_OE_N_O
);
	import ssp_pkg::*;

	// ----------------------------------------
	// Pin synchronisers and edge finders
	// ----------------------------------------
	ssp_pins_s pin_raw, s1_r, s2_r;
	logic [3:0] edge_r;
	logic k_rise, kn_rise, op_rise, on_rise;

	// Write lane enables from the active-low masks
	function automatic ssp_word_t keep_mask(
		input logic [`SSP_LANES-1:0] bws_n,
		input logic [`SSP_NIBS-1:0] nws_n
	);
		ssp_word_t m;
		m = '0;
		for (int i = 0; i < `SSP_LANES; i++) begin
			m[i*`SSP_LANE_W +: `SSP_LANE_W] = {`SSP_LANE_W{~bws_n[i]}};
		end
		if (`SSP_NIBBLE_MODE) begin
			m = '0;
			for (int i = 0; i < `SSP_NIBS; i++) begin
				m[i*`SSP_NIB_W +: `SSP_NIB_W] = {`SSP_NIB_W{~nws_n[i]}};
			end
		end
		return m;
	endfunction

	// Bundle the pins; every one crosses two flops before use
	assign pin_raw = {CAPTURE_CLOCK_P_I, CAPTURE_CLOCK_N_I, OUTPUT_CLOCK_P_I,
		OUTPUT_CLOCK_N_I, SINGLE_CLOCK_MODE_I, WRITE_PORT_SELECT_N_I,
		READ_PORT_SELECT_N_I, SHARED_ADDR_BUS_I, WRITE_DATA_IN_I,
		BYTE_WRITE_SELECT_N_I, NIBBLE_WRITE_SELECT_N_I};

	// Synchroniser stages and previous clock levels
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			s1_r <= '0;
			s2_r <= '0;
			edge_r <= 4'hf; // No false rise right after reset
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			edge_r <= {s2_r.k, s2_r.kn, s2_r.c, s2_r.cn};
		end
	end

	// Rising edges; single clock mode times reads from the capture pair
	assign k_rise = s2_r.k & ~edge_r[3];
	assign kn_rise = s2_r.kn & ~edge_r[2];
	assign op_rise = s2_r.single ? k_rise : (s2_r.c & ~edge_r[1]);
	assign on_rise = s2_r.single ? kn_rise : (s2_r.cn & ~edge_r[0]);

	// ----------------------------------------
	// Write capture
	// ----------------------------------------
	ssp_wr_e wr_st_r, wr_st_nxt;
	logic [`SSP_IDX_W-1:0] wr_idx_r, wr_idx_nxt;
	logic wr_again_r, wr_again_nxt;
	logic beat_v_r, beat_v_nxt;
	ssp_beat_s beat_r, beat_nxt;
	logic fifo_in_rdy;

	// Select, address and beat sequencing
	always_comb begin
		logic take;
		logic [1:0] word;
		logic [`SSP_IDX_W-1:0] idx;
		take = 1'b0;
		word = 2'h0;
		idx = wr_idx_r;
		wr_st_nxt = wr_st_r;
		wr_idx_nxt = wr_idx_r;
		wr_again_nxt = wr_again_r;
		beat_nxt = beat_r;
		beat_v_nxt = beat_v_r & ~fifo_in_rdy;
		case (wr_st_r)
			SSP_WR_IDLE: begin
				if (k_rise && !s2_r.wps_n) begin
					wr_st_nxt = SSP_WR_ARM;
				end
			end
			SSP_WR_ARM: begin
				if (k_rise) begin
					idx = s2_r.addr[`SSP_IDX_W-1:0];
					wr_idx_nxt = idx;
					take = 1'b1;
					word = 2'h0;
					wr_st_nxt = SSP_WR_B1;
				end
			end
			SSP_WR_B1: begin
				if (kn_rise) begin
					take = 1'b1;
					word = 2'h1;
					wr_st_nxt = SSP_WR_B2;
				end
			end
			SSP_WR_B2: begin
				if (k_rise) begin
					take = 1'b1;
					word = 2'h2;
					wr_again_nxt = !s2_r.wps_n;
					wr_st_nxt = SSP_WR_B3;
				end
			end
			SSP_WR_B3: begin
				if (kn_rise) begin
					take = 1'b1;
					word = 2'h3;
					wr_again_nxt = 1'b0;
					wr_st_nxt = wr_again_r ? SSP_WR_ARM : SSP_WR_IDLE;
				end
			end
			default: begin
				wr_st_nxt = SSP_WR_IDLE;
			end
		endcase
		if (take) begin
			beat_v_nxt = 1'b1;
			beat_nxt.idx = idx;
			beat_nxt.word = word;
			beat_nxt.data = s2_r.d;
			beat_nxt.keep = keep_mask(s2_r.bws_n, s2_r.nws_n);
		end
	end

	// Write capture registers
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			wr_st_r <= SSP_WR_IDLE;
			wr_idx_r <= '0;
			wr_again_r <= 1'b0;
			beat_v_r <= 1'b0;
			beat_r <= '0;
		end else begin
			wr_st_r <= wr_st_nxt;
			wr_idx_r <= wr_idx_nxt;
			wr_again_r <= wr_again_nxt;
			beat_v_r <= beat_v_nxt;
			beat_r <= beat_nxt;
		end
	end

	// ----------------------------------------
	// Write FIFO and array
	// ----------------------------------------
	logic fetch_r, fetch_nxt;
	logic fifo_out_v, pop;
	ssp_beat_s fifo_out;
	ssp_word_t mem_r [`SSP_BURST][`SSP_MEM_DEPTH];

	// The array drain stalls in a read fetch cycle
	ssp_fifo #(
		.W($bits(ssp_beat_s)),
		.DEPTH(`SSP_FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.in_valid_i(beat_v_r),
		.in_ready_o(fifo_in_rdy),
		.in_data_i(beat_r),
		.out_valid_o(fifo_out_v),
		.out_ready_i(!fetch_r),
		.out_data_o(fifo_out)
	);
	assign pop = fifo_out_v & !fetch_r;

	// One sub-array per burst word; only enabled bits change
	for (genvar g = 0; g < `SSP_BURST; g++) begin : g_sub
		always_ff @(posedge CLOCK_I) begin
			if (pop && fifo_out.word == 2'(g)) begin
				mem_r[g][fifo_out.idx] <= (mem_r[g][fifo_out.idx] & ~fifo_out.keep)
					| (fifo_out.data & fifo_out.keep);
			end
		end
	end

	// ----------------------------------------
	// Read fetch and output
	// ----------------------------------------
	logic [`SSP_IDX_W-1:0] rd_idx_r, rd_idx_nxt;
	ssp_word_t buf_r [`SSP_BURST];
	ssp_word_t buf_nxt [`SSP_BURST];
	ssp_word_t out_r [`SSP_BURST];
	ssp_word_t out_nxt [`SSP_BURST];
	logic buf_v_r, buf_v_nxt;
	ssp_rd_e rd_st_r, rd_st_nxt;
	logic [1:0] rd_cnt_r, rd_cnt_nxt;
	ssp_word_t q_r, q_nxt;
	logic oe_n_r, oe_n_nxt;
	logic start;

	assign start = op_rise && buf_v_r && rd_st_r != SSP_RD_BURST;

	// Read address, fetch and beat sequencing
	always_comb begin
		rd_idx_nxt = rd_idx_r;
		fetch_nxt = 1'b0;
		buf_nxt = buf_r;
		buf_v_nxt = buf_v_r;
		out_nxt = out_r;
		rd_st_nxt = rd_st_r;
		rd_cnt_nxt = rd_cnt_r;
		q_nxt = q_r;
		oe_n_nxt = oe_n_r;
		if (k_rise && !s2_r.rps_n) begin
			rd_idx_nxt = s2_r.addr[`SSP_IDX_W-1:0];
			fetch_nxt = 1'b1;
		end
		case (rd_st_r)
			SSP_RD_IDLE, SSP_RD_TAIL: begin
				if (start) begin
					out_nxt = buf_r;
					q_nxt = buf_r[0];
					oe_n_nxt = 1'b0;
					rd_cnt_nxt = 2'h1;
					buf_v_nxt = 1'b0;
					rd_st_nxt = SSP_RD_BURST;
				end else if (rd_st_r == SSP_RD_TAIL && op_rise) begin
					oe_n_nxt = `SSP_OE_OFF;
					rd_st_nxt = SSP_RD_IDLE;
				end
			end
			SSP_RD_BURST: begin
				if (rd_cnt_r[0] ? on_rise : op_rise) begin
					q_nxt = out_r[rd_cnt_r];
					rd_cnt_nxt = rd_cnt_r + 2'h1;
					if (rd_cnt_r == 2'h3) begin
						rd_st_nxt = SSP_RD_TAIL;
					end
				end
			end
			default: begin
				rd_st_nxt = SSP_RD_IDLE;
				oe_n_nxt = `SSP_OE_OFF;
			end
		endcase
		if (fetch_r) begin
			for (int w = 0; w < `SSP_BURST; w++) begin
				buf_nxt[w] = mem_r[w][rd_idx_r];
			end
			buf_v_nxt = 1'b1; // Fetch wins over a start clear
		end
	end

	// Read registers
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			rd_idx_r <= '0;
			fetch_r <= 1'b0;
			buf_r <= '{default: '0};
			buf_v_r <= 1'b0;
			out_r <= '{default: '0};
			rd_st_r <= SSP_RD_IDLE;
			rd_cnt_r <= 2'h0;
			q_r <= `SSP_Q_RST;
			oe_n_r <= `SSP_OE_OFF;
		end else begin
			rd_idx_r <= rd_idx_nxt;
			fetch_r <= fetch_nxt;
			buf_r <= buf_nxt;
			buf_v_r <= buf_v_nxt;
			out_r <= out_nxt;
			rd_st_r <= rd_st_nxt;
			rd_cnt_r <= rd_cnt_nxt;
			q_r <= q_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign READ_DATA_OUT_O = q_r;
	assign READ_DATA_OUT_OE_N_O = oe_n_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic chk_v_r;
	logic [1:0] chk_w_r;
	logic [`SSP_IDX_W-1:0] chk_i_r;
	ssp_word_t chk_e_r;

	// Expected array word after each drained beat
	always_ff @(posedge CLOCK_I) begin
		chk_v_r <= RESET_N_I && pop;
		chk_w_r <= fifo_out.word;
		chk_i_r <= fifo_out.idx;
		chk_e_r <= (mem_r[fifo_out.word][fifo_out.idx] & ~fifo_out.keep)
			| (fifo_out.data & fifo_out.keep);
	end

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);

	sequence seq_fetch;
		fetch_r ##1 buf_v_r;
	endsequence
	sequence seq_start;
		op_rise && buf_v_r && rd_st_r != SSP_RD_BURST;
	endsequence

	AST_WR_ARM: assert property (
		k_rise && !s2_r.wps_n && wr_st_r == SSP_WR_IDLE |=> wr_st_r == SSP_WR_ARM)
		else $error("write select low did not arm a write");
	AST_WR_DESEL: assert property (
		k_rise && s2_r.wps_n && wr_st_r == SSP_WR_IDLE |=> wr_st_r == SSP_WR_IDLE)
		else $error("deselected write port started a write");
	AST_BEAT_EDGE: assert property (
		$rose(beat_v_r) |-> $past(k_rise || kn_rise))
		else $error("write beat taken off a capture edge");
	AST_MASK: assert property (
		$rose(beat_v_r) |-> beat_r.keep == keep_mask($past(s2_r.bws_n), $past(s2_r.nws_n)))
		else $error("write mask not from the beat edge");
	AST_MEM_KEEP: assert property (
		chk_v_r |-> mem_r[chk_w_r][chk_i_r] == chk_e_r)
		else $error("masked lanes changed or data lost");
	AST_RD_ADDR: assert property (
		k_rise && !s2_r.rps_n |=> seq_fetch and rd_idx_r == $past(s2_r.addr[3:0]))
		else $error("read select did not fetch its address");
	AST_RD_IGN: assert property (
		k_rise && s2_r.rps_n |=> $stable(rd_idx_r) && !fetch_r)
		else $error("address taken for deselected read port");
	AST_Q_EDGE: assert property (
		$changed(q_r) |-> $past(op_rise || on_rise))
		else $error("read data changed off an output clock edge");
	AST_TRI: assert property (
		rd_st_r == SSP_RD_IDLE |-> oe_n_r)
		else $error("read data driven while idle");
	AST_BURST: assert property (
		seq_start |=> !oe_n_r && rd_st_r == SSP_RD_BURST && rd_cnt_r == 2'h1)
		else $error("read burst did not start with its first beat");
	AST_TAIL: assert property (
		rd_st_r == SSP_RD_TAIL && op_rise && !buf_v_r |=> oe_n_r && rd_st_r == SSP_RD_IDLE)
		else $error("outputs not floated after burst tail");
endmodule // ssp_sram_split_port

// ===== dv/ssp_ctl_model.sv
// External memory controller model that drives the link pins of the SRAM
`timescale 1ns/1ps
`include "ssp_defs.svh"

// ----------------------------------------
// Controller model
// ----------------------------------------
module ssp_ctl_model (
	// Mode strap seen by the controller
	input wire logic single_i,
	// Link clocks
	output logic k_o,
	output logic kn_o,
	output logic c_o,
	output logic cn_o,
	// Selects, address and write data
	output logic wps_n_o,
	output logic rps_n_o,
	output logic [`SSP_AW-1:0] addr_o,
	output ssp_pkg::ssp_word_t d_o,
	output logic [`SSP_LANES-1:0] bws_n_o
);
	import ssp_pkg::*;

	// Output clocks follow the capture pair, and stand still in single clock mode
	assign c_o = k_o & ~single_i;
	assign cn_o = kn_o & ~single_i;

	// Quiet pins until the first period
	initial begin
		k_o = 1'b0;
		kn_o = 1'b0;
		wps_n_o = 1'b1;
		rps_n_o = 1'b1;
		addr_o = '0;
		d_o = '0;
		bws_n_o = 4'hf;
	end

	// One capture period: values for the K rise, then values for the Kn rise
	task automatic per(input logic wps_n, input logic rps_n, input logic [`SSP_AW-1:0] a,
		input ssp_word_t d0, input logic [3:0] m0, input ssp_word_t d1, input logic [3:0] m1);
		wps_n_o = wps_n;
		rps_n_o = rps_n;
		addr_o = a;
		d_o = d0;
		bws_n_o = m0;
		#50 k_o = 1'b1;
		kn_o = 1'b0;
		#50 addr_o = ~addr_o; // Released address turns over so stale values are not reused
		wps_n_o = 1'b1;
		rps_n_o = 1'b1;
		d_o = d1;
		bws_n_o = m1;
		#50 k_o = 1'b0;
		kn_o = 1'b1;
		#50;
	endtask

	// Stop the link clocks and turn over the released data lines
	task automatic stop();
		#50 kn_o = 1'b0;
		d_o = ~d_o;
		bws_n_o = ~bws_n_o;
	endtask
endmodule // ssp_ctl_model

// ===== dv/tb.sv
// Self-checking testbench of the split-port burst SRAM
`timescale 1ns/1ps
`include "ssp_defs.svh"

module tb;
	import ssp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic single = 1'b0;
	logic k, kn, c, cn, wps_n, rps_n, oe_n;
	logic [`SSP_AW-1:0] addr;
	logic [3:0] bws_n;
	ssp_word_t d, q;
	ssp_word_t mem_m [16][4];
	logic [31:0] lfsr_r = 32'h27;
	int error_cnt = 0;
	int checks_done = 0;

	// System clock, 25 ns period
	always #12.5 clk = ~clk;

	ssp_ctl_model ctl (.single_i(single), .k_o(k), .kn_o(kn), .c_o(c), .cn_o(cn),
		.wps_n_o(wps_n), .rps_n_o(rps_n), .addr_o(addr), .d_o(d), .bws_n_o(bws_n));

	ssp_sram_split_port uut (.CLOCK_I(clk), .RESET_N_I(rst_n), .CAPTURE_CLOCK_P_I(k),
		.CAPTURE_CLOCK_N_I(kn), .OUTPUT_CLOCK_P_I(c), .OUTPUT_CLOCK_N_I(cn),
		.SINGLE_CLOCK_MODE_I(single), .WRITE_PORT_SELECT_N_I(wps_n),
		.READ_PORT_SELECT_N_I(rps_n), .SHARED_ADDR_BUS_I(addr), .WRITE_DATA_IN_I(d),
		.BYTE_WRITE_SELECT_N_I(bws_n), .NIBBLE_WRITE_SELECT_N_I(bws_n[1:0]),
		.READ_DATA_OUT_O(q), .READ_DATA_OUT_OE_N_O(oe_n));

	// Pseudo-random source, fixed start value
	function automatic ssp_word_t rnd();
		for (int i = 0; i < 2; i++) begin
			lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		end
		return {lfsr_r[7:4], lfsr_r};
	endfunction

	// Expected word after a masked write: only enabled 9-bit lanes change
	function automatic ssp_word_t merge(ssp_word_t old, ssp_word_t nw, logic [3:0] m);
		ssp_word_t r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (!m[i]) begin
				r[i*9 +: 9] = nw[i*9 +: 9];
			end
		end
		return r;
	endfunction

	// Compare of a data word
	task automatic chk_w(input string nm, input ssp_word_t e, input ssp_word_t g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Compare of a single flag
	task automatic chk_b(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// One frame: optional write, optional read of another index, three trailing periods
	task automatic op(input bit wr, input bit rd, input bit full, input int fix);
		ssp_word_t t, dv [4], ev [4];
		logic [3:0] mv [4];
		logic [`SSP_AW-1:0] wa, ra;
		t = rnd();
		wa = t[`SSP_AW-1:0];
		if (fix >= 0) begin
			wa[3:0] = fix[3:0];
		end
		t = rnd();
		ra = t[`SSP_AW-1:0];
		ra[3:0] = wa[3:0] ^ {t[31:29], 1'b1};
		for (int j = 0; j < 4; j++) begin
			dv[j] = rnd();
			t = rnd();
			mv[j] = full ? 4'h0 : t[3:0];
			ev[j] = mem_m[ra[3:0]][j];
			if (wr) begin
				mem_m[wa[3:0]][j] = merge(mem_m[wa[3:0]][j], dv[j], mv[j]);
			end
		end
		@(negedge clk);
		ctl.per(~wr, 1'b1, ~wa, dv[2], 4'h0, dv[3], 4'h0);
		ctl.per(1'b1, 1'b1, wa, dv[0], mv[0], dv[1], mv[1]);
		ctl.per(1'b1, ~rd, ra, dv[2], mv[2], dv[3], mv[3]);
		fork
			begin
				for (int j = 0; j < 3; j++) begin
					ctl.per(1'b1, 1'b1, ~ra, rnd(), 4'h0, rnd(), 4'h0);
				end
				ctl.stop();
			end
			begin
				@(posedge k);
				for (int j = 0; j < 4 && rd; j++) begin
					#(j == 0 ? 140 : 100);
					chk_b("read drive", 1'b0, oe_n);
					chk_w("read beat", ev[j], q);
				end
				#100;
				chk_b("read float", 1'b1, oe_n);
			end
		join
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk_b("oe after reset", 1'b1, oe_n);
		chk_w("data after reset", '0, q);
		repeat (3) @(negedge clk);
		for (int i = 0; i < 16; i++) begin
			op(1'b1, 1'b0, 1'b1, i);
		end
		for (int p = 0; p < 2; p++) begin
			@(negedge clk);
			single <= p[0];
			for (int i = 0; i < 32; i++) begin
				ssp_word_t t;
				t = rnd();
				op(t[0] | (i < 2), t[1] | (i < 2), t[2] & t[3], -1);
			end
		end
		close_out();
	end

	// Watchdog for a hung run
	initial begin
		#500000;
		error_cnt++;
		close_out();
	end
endmodule // tb
